// file: shared/cpusv_map.vh
// bit positions, reset values and opcode codes for the status/vector block
`ifndef CPUSV_MAP_VH
`define CPUSV_MAP_VH
`define CPUSV_PRIV_BIT 30
`define CPUSV_BANK_BIT 29
`define CPUSV_BLOCK_BIT 28
`define CPUSV_MASK_HI 7
`define CPUSV_MASK_LO 4
`define CPUSV_DSIGN_BIT 9
`define CPUSV_QSTEP_BIT 8
`define CPUSV_SAT_BIT 1
`define CPUSV_COND_BIT 0
`define CPUSV_VB_RESET 32'h00000000
`define CPUSV_MASK_RESET 4'hF
`define CPUSV_SEL_STATUS 2'h0
`define CPUSV_SEL_VBASE 2'h1
`define CPUSV_SEL_GBASE 2'h2
`define CPUSV_FLAG_DSIGN 2'h3
`define CPUSV_FLAG_QSTEP 2'h2
`define CPUSV_FLAG_SAT 2'h1
`define CPUSV_FLAG_COND 2'h0
`endif

// file: rtl/cpusv_regs.v
// processor status word, vector base and global base register
`timescale 1ns/1ps
`include "cpusv_map.vh"
module cpusv_regs (
    input wire clk,
    input wire nrst,
    // control load / store from the core
    input wire ctl_wr,
    input wire ctl_rd,
    input wire [1:0] ctl_sel,
    input wire [31:0] ctl_wdata,
    output reg [31:0] ctl_rdata,
    output reg ctl_fault,
    // single-flag update from flag instructions
    input wire flag_wr,
    input wire [1:0] flag_sel,
    input wire flag_val,
    // exception or interrupt accepted this cycle
    input wire evt_take,
    input wire evt_req,
    output reg evt_accept,
    output reg privilege_mode_bit,
    output reg bank_select_bit,
    output reg event_block_bit,
    output reg [3:0] level_mask_field,
    output reg div_sign_flag,
    output reg quot_step_flag,
    output reg sat_flag,
    output reg cond_flag,
    output reg [31:0] vector_base,
    output reg [31:0] global_base
);
    reg [31:0] status_word;
    reg priv_ok;
    reg wr_ok;
    reg st_wr;
    reg vb_wr;
    reg gb_wr;

    // next values of the privileged fields
    reg priv_d;
    reg bank_d;
    reg block_d;
    reg [3:0] mask_d;
    reg [31:0] vb_d;
    reg [31:0] gb_d;

    // next values of the user flags
    reg dsign_d;
    reg qstep_d;
    reg sat_d;
    reg cond_d;

    // next values of the read port and status pulses
    reg [31:0] rdata_d;
    reg fault_d;
    reg accept_d;

    // one target decode shared by the write, read and fault paths
    function sel_is;
        input [1:0] sel;
        input [1:0] code;
        begin
            sel_is = (sel == code);
        end
    endfunction

    // assemble the word; unused bits are hardwired zero
    always @* begin
        status_word = 32'h00000000;
        status_word[`CPUSV_PRIV_BIT] = privilege_mode_bit;
        status_word[`CPUSV_BANK_BIT] = bank_select_bit;
        status_word[`CPUSV_BLOCK_BIT] = event_block_bit;
        status_word[`CPUSV_MASK_HI:`CPUSV_MASK_LO] = level_mask_field;
        status_word[`CPUSV_DSIGN_BIT] = div_sign_flag;
        status_word[`CPUSV_QSTEP_BIT] = quot_step_flag;
        status_word[`CPUSV_SAT_BIT] = sat_flag;
        status_word[`CPUSV_COND_BIT] = cond_flag;
    end

    // user mode may only reach global base
    always @* begin
        priv_ok = privilege_mode_bit || sel_is(ctl_sel, `CPUSV_SEL_GBASE);
        wr_ok = ctl_wr && priv_ok;
        st_wr = wr_ok && sel_is(ctl_sel, `CPUSV_SEL_STATUS);
        vb_wr = wr_ok && sel_is(ctl_sel, `CPUSV_SEL_VBASE);
        gb_wr = wr_ok && sel_is(ctl_sel, `CPUSV_SEL_GBASE);
    end

    // privileged fields; exception entry overrides a same-cycle write
    always @* begin
        priv_d = privilege_mode_bit;
        bank_d = bank_select_bit;
        block_d = event_block_bit;
        mask_d = level_mask_field;
        vb_d = vector_base;
        gb_d = global_base;
        if (st_wr) begin
            priv_d = ctl_wdata[`CPUSV_PRIV_BIT];
            bank_d = ctl_wdata[`CPUSV_BANK_BIT];
            block_d = ctl_wdata[`CPUSV_BLOCK_BIT];
            mask_d = ctl_wdata[`CPUSV_MASK_HI:`CPUSV_MASK_LO];
        end
        if (vb_wr) begin
            vb_d = ctl_wdata;
        end
        if (gb_wr) begin
            gb_d = ctl_wdata;
        end
        // mask level is deliberately left alone on entry
        if (evt_take) begin
            priv_d = 1'b1;
            bank_d = 1'b1;
            block_d = 1'b1;
        end
    end

    // flag instructions work in any mode and win over a word write
    always @* begin
        dsign_d = div_sign_flag;
        qstep_d = quot_step_flag;
        sat_d = sat_flag;
        cond_d = cond_flag;
        if (st_wr) begin
            dsign_d = ctl_wdata[`CPUSV_DSIGN_BIT];
            qstep_d = ctl_wdata[`CPUSV_QSTEP_BIT];
            sat_d = ctl_wdata[`CPUSV_SAT_BIT];
            cond_d = ctl_wdata[`CPUSV_COND_BIT];
        end
        if (flag_wr) begin
            case (flag_sel)
                `CPUSV_FLAG_DSIGN: dsign_d = flag_val;
                `CPUSV_FLAG_QSTEP: qstep_d = flag_val;
                `CPUSV_FLAG_SAT: sat_d = flag_val;
                default: cond_d = flag_val;
            endcase
        end
    end

    // read data is zero unless a permitted read is under way
    always @* begin
        rdata_d = 32'h00000000;
        if (ctl_rd && priv_ok) begin
            case (ctl_sel)
                `CPUSV_SEL_STATUS: rdata_d = status_word;
                `CPUSV_SEL_VBASE: rdata_d = vector_base;
                `CPUSV_SEL_GBASE: rdata_d = global_base;
                // spare target: reads zero, writes are dropped
                default: rdata_d = 32'h00000000;
            endcase
        end
        fault_d = (ctl_wr || ctl_rd) && !priv_ok;
        // a request is looked at against the block bit as it stands now
        accept_d = evt_req && !event_block_bit;
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            privilege_mode_bit <= 1'b1;
            bank_select_bit <= 1'b1;
            event_block_bit <= 1'b1;
            level_mask_field <= `CPUSV_MASK_RESET;
            vector_base <= `CPUSV_VB_RESET;
            global_base <= 32'h00000000;
        end else begin
            privilege_mode_bit <= priv_d;
            bank_select_bit <= bank_d;
            event_block_bit <= block_d;
            level_mask_field <= mask_d;
            vector_base <= vb_d;
            global_base <= gb_d;
        end
    end

    // user flags: no reset, so they stay undefined until written
    always @(posedge clk) begin
        div_sign_flag <= dsign_d;
        quot_step_flag <= qstep_d;
        sat_flag <= sat_d;
        cond_flag <= cond_d;
    end

    // registered read port, fault on privileged access from user mode
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_rdata <= 32'h00000000;
            ctl_fault <= 1'b0;
            evt_accept <= 1'b0;
        end else begin
            ctl_rdata <= rdata_d;
            ctl_fault <= fault_d;
            evt_accept <= accept_d;
        end
    end
endmodule // cpusv_regs

// file: sim/cpusv_chk.sv
// status block checker
`timescale 1ns/1ps
module cpusv_chk (input clk, nrst, ctl_wr, ctl_rd, ctl_fault,
    input evt_take, evt_accept, privilege_mode_bit, bank_select_bit,
    input event_block_bit, input [1:0] ctl_sel,
    input [31:0] ctl_wdata, ctl_rdata, vector_base);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    mode_set_a: assert property (evt_take |=> privilege_mode_bit)
        else $error("mode");
    bank_set_a: assert property (evt_take |=> bank_select_bit)
        else $error("bank");
    block_set_a: assert property (evt_take |=> event_block_bit)
        else $error("block");
    no_accept_a: assert property (event_block_bit |=> !evt_accept)
        else $error("accept");
    vb_write_a: assert property (privilege_mode_bit && ctl_wr &&
        ctl_sel == 2'h1 |=> vector_base == $past(ctl_wdata)) else $error("vb");
    user_fault_a: assert property (!privilege_mode_bit &&
        ctl_wr && ctl_sel != 2'h2 |=> ctl_fault) else $error("fault");
    gbase_ok_a: assert property (ctl_wr && ctl_sel == 2'h2 |=>
        !ctl_fault) else $error("gbase");
    zero_bits_a: assert property (ctl_rd && ctl_sel == 2'h0 |=>
        (ctl_rdata & 32'h8FFFFC0C) == 32'h0) else $error("zero");
endmodule // cpusv_chk
bind cpusv_regs cpusv_chk u_chk (.*);

// file: sim/tb.sv
// status block bench
`timescale 1ns/1ps
module tb;
    reg clk, nrst, ctl_wr, ctl_rd, flag_wr, flag_val, evt_take, evt_req;
    reg [1:0] ctl_sel, flag_sel;
    reg [31:0] ctl_wdata;
    wire [31:0] ctl_rdata, vector_base, global_base;
    wire [3:0] level_mask_field;
    wire ctl_fault, evt_accept, privilege_mode_bit, bank_select_bit;
    wire event_block_bit, div_sign_flag, quot_step_flag, sat_flag, cond_flag;
    integer error_cnt = 0, checked = 0;
    cpusv_regs dut (.*);
    initial forever #5 clk = ~clk;
    initial #9000 begin error_cnt = error_cnt + 1; final_report; end
    task chk(input [32:0] g, input [32:0] e); begin
        checked = checked + 1;
        if (g !== e) $display("[ERR] %0t %h %h", $time, g, e);
        if (g !== e) error_cnt = error_cnt + 1;
    end endtask
    task op(input [1:0] k, input [1:0] s, input [31:0] d); begin
        @(posedge clk) #1 {ctl_wr, ctl_rd, ctl_sel, ctl_wdata} = {k, s, d};
        @(posedge clk) #1 {ctl_wr, ctl_rd} = 2'h0;
    end endtask
    task flag(input [1:0] s, input v); begin
        @(posedge clk) #1 {flag_wr, flag_sel, flag_val} = {1'b1, s, v};
        @(posedge clk) #1 flag_wr = 1'h0;
    end endtask
    task final_report; begin
        $display("%0d checks %0d errors", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    end endtask
    initial begin
        {clk, nrst, ctl_wr, ctl_rd, flag_wr, flag_val, evt_take} = 7'h0;
        {evt_req, ctl_sel, flag_sel, ctl_wdata} = 37'h0;
        #36 nrst = 1'h1;
        op(2'h1, 2'h0, 32'h0);
        chk(ctl_rdata & 32'hFFFFFCFC, 32'h700000F0);
        op(2'h2, 2'h0, 32'h400002A1);
        evt_req = 1'h1;
        op(2'h1, 2'h0, 32'h0);
        chk({evt_accept, ctl_rdata}, 33'h1400002A1);
        evt_take = 1'h1;
        @(posedge clk) #1 evt_take = 1'h0;
        op(2'h1, 2'h0, 32'h0);
        chk({evt_accept, ctl_rdata}, 33'h0700002A1);
        $display("test 1 done");
        op(2'h2, 2'h0, 32'h0);
        op(2'h2, 2'h1, 32'h12345678);
        chk({ctl_fault, vector_base}, 33'h100000000);
        op(2'h2, 2'h2, 32'h12345678);
        chk({ctl_fault, global_base}, 33'h012345678);
        $display("test 2 done");
        flag(2'h3, 1'h1);
        flag(2'h2, 1'h1);
        flag(2'h1, 1'h1);
        chk({div_sign_flag, quot_step_flag, sat_flag,
            cond_flag}, 4'hE);
        flag(2'h0, 1'h1);
        flag(2'h2, 1'h0);
        evt_take = 1'h1;
        @(posedge clk) #1 evt_take = 1'h0;
        chk({privilege_mode_bit, bank_select_bit, event_block_bit,
            level_mask_field}, 7'h70);
        op(2'h1, 2'h0, 32'h0);
        chk(ctl_rdata, 32'h70000203);
        $display("test 3 done");
        final_report;
    end
endmodule // tb
